// [gpa_port.sv]
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - A direction bit of 1 floats the pin as input, 0 drives the output latch onto it.
// - Reading pin_level_a returns pin levels, writing it loads the output latch.
// - Reading output_latch_a returns the latch itself, so read-modify-write is safe.
// - Bits 7 and 6 act as I/O only when the oscillator mode frees them, else read zero.
// - Bit 6 carries the cycle clock (system clock over four) only in the three cycle-clock-out modes.
// - Bit 7 loses digital input and output whenever an external oscillator uses it.
// - The four-bit port_config_field picks analog or digital for pins 3..0 and 5; bit 4 stays digital.
// - After reset bits 5 and 3..0 are analog and read zero, bit 4 is a digital input.
// - An analog pin reads zero digitally but its output driver still works.
// - Bit 4 feeds the timer clock input at any direction and drives open-drain low only.
// - Bit 2 loses digital input and output while the comparator reference drives it.
// - A peripheral that claims a pin takes it over from general-purpose I/O.
// - The port is eight bits, each with direction, latch and pin read path.
module gpa_port (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [gpa_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // device configuration
  input wire gpa_pkg::gpa_osc_mode_t osc_mode_i,
  input wire logic comparator_ref_out_i,
  input wire gpa_pkg::gpa_periph_t periph_i,
  // pins
  input wire logic [gpa_pkg::PORT_W-1:0] pin_i,
  output logic [gpa_pkg::PORT_W-1:0] pin_o,
  output logic [gpa_pkg::PORT_W-1:0] pin_oe_n_o,
  // peripheral taps
  output logic timer_ext_clock_in_o,
  output logic cycle_clock_out_o,
  output logic [gpa_pkg::PORT_W-1:0] analog_sel_o
);

  // whole block state
  typedef struct packed {
    logic [gpa_pkg::PORT_W-1:0] lat;
    logic [gpa_pkg::PORT_W-1:0] dir;
    logic [gpa_pkg::CFG_W-1:0] cfg;
    logic [7:0] rdata;
    logic [gpa_pkg::DIV_W-1:0] div;
    logic [gpa_pkg::PORT_W-1:0] pin_out;
    logic [gpa_pkg::PORT_W-1:0] pin_oe_n;
  } gpa_st_t;

  gpa_st_t st_q;
  gpa_st_t st_d;

  gpa_pkg::gpa_bus_req_t req;
  logic [gpa_pkg::PORT_W-1:0] pin_sync;
  logic [gpa_pkg::PORT_W-1:0] analog;
  logic [gpa_pkg::PORT_W-1:0] gp_avail;
  logic [gpa_pkg::PORT_W-1:0] in_en;
  logic [gpa_pkg::PORT_W-1:0] out_en;
  logic [gpa_pkg::PORT_W-1:0] drv_val;
  logic [gpa_pkg::PORT_W-1:0] drv_oe_n;
  logic bit6_io;
  logic bit7_io;
  logic cycle_clock_out_on;

  // bundle the register strobes
  assign req.addr = addr_i;
  assign req.wdata = wdata_i;
  assign req.we = we_i;
  assign req.re = re_i;

  // pins are asynchronous to the system clock
  gpa_sync #(
    .W(gpa_pkg::PORT_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_i),
    .level_o(pin_sync)
  );

  // analog selection from the converter configuration
  gpa_ana_dec u_dec (
    .cfg_i(st_q.cfg),
    .analog_o(analog)
  );

  // oscillator mode decides what bits 6 and 7 are
  always_comb begin
    bit6_io = 1'b0;
    bit7_io = 1'b0;
    cycle_clock_out_on = 1'b0;
    case (osc_mode_i)
      gpa_pkg::GPA_OSC_XTAL: begin
        bit6_io = 1'b0;
      end
      gpa_pkg::GPA_OSC_EXT_CYCLE_CLOCK_OUT: begin
        cycle_clock_out_on = 1'b1;
      end
      gpa_pkg::GPA_OSC_EXT_IO: begin
        bit6_io = 1'b1;
      end
      gpa_pkg::GPA_OSC_RC_CYCLE_CLOCK_OUT: begin
        cycle_clock_out_on = 1'b1;
      end
      gpa_pkg::GPA_OSC_RC_IO: begin
        bit6_io = 1'b1;
      end
      gpa_pkg::GPA_OSC_INT_CYCLE_CLOCK_OUT: begin
        cycle_clock_out_on = 1'b1;
        bit7_io = 1'b1;
      end
      gpa_pkg::GPA_OSC_INT_IO: begin
        bit6_io = 1'b1;
        bit7_io = 1'b1;
      end
      default: begin
        bit6_io = 1'b0;
      end
    endcase
  end

  // bits usable as general-purpose I/O at all
  always_comb begin
    gp_avail = '1;
    gp_avail[gpa_pkg::BIT_SIX] = bit6_io;
    gp_avail[gpa_pkg::BIT_SEVEN] = bit7_io;
  end

  // digital output path: not cut by analog, cut by reference output and claims
  always_comb begin
    out_en = gp_avail & ~periph_i.own;
    if (comparator_ref_out_i) begin
      out_en[gpa_pkg::BIT_REF_LOW] = 1'b0;
    end
  end

  // digital input path: analog pins, reference output and claims read zero
  always_comb begin
    in_en = gp_avail & ~analog & ~periph_i.own;
    if (comparator_ref_out_i) begin
      in_en[gpa_pkg::BIT_REF_LOW] = 1'b0;
    end
  end

  // per-pin driver selection
  for (genvar i = 0; i < gpa_pkg::PORT_W; i++) begin : g_pin
    always_comb begin
      drv_val[i] = 1'b0;
      drv_oe_n[i] = 1'b1;
      if (periph_i.own[i]) begin
        // the peripheral drives or floats the pin as it likes
        drv_val[i] = periph_i.dat[i];
        drv_oe_n[i] = ~periph_i.drv[i];
      end else if ((i == gpa_pkg::BIT_SIX) && cycle_clock_out_on) begin
        drv_val[i] = st_q.div[gpa_pkg::DIV_W-1];
        drv_oe_n[i] = 1'b0;
      end else if (!out_en[i]) begin
        drv_oe_n[i] = 1'b1;
      end else if (i == gpa_pkg::BIT_FOUR) begin
        // open drain: only a low latch enables the driver
        drv_val[i] = 1'b0;
        drv_oe_n[i] = st_q.dir[i] | st_q.lat[i];
      end else begin
        // analog pins keep this driver, so software holds dir set there
        drv_val[i] = st_q.lat[i];
        drv_oe_n[i] = st_q.dir[i];
      end
    end
  end

  // register writes, read capture and divider
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.div = st_q.div + 1'b1;
    st_d.pin_out = drv_val;
    st_d.pin_oe_n = drv_oe_n;
    if (req.we) begin
      case (req.addr)
        gpa_pkg::OFS_PIN_LEVEL: begin
          st_d.lat = req.wdata;
        end
        gpa_pkg::OFS_OUT_LATCH: begin
          st_d.lat = req.wdata;
        end
        gpa_pkg::OFS_DIRECTION: begin
          st_d.dir = req.wdata;
        end
        gpa_pkg::OFS_CONV_CFG: begin
          st_d.cfg = req.wdata[gpa_pkg::CFG_W-1:0];
        end
        default: begin
          st_d.cfg = st_q.cfg;
        end
      endcase
    end
    if (req.re) begin
      case (req.addr)
        gpa_pkg::OFS_PIN_LEVEL: begin
          st_d.rdata = pin_sync & in_en;
        end
        gpa_pkg::OFS_OUT_LATCH: begin
          st_d.rdata = st_q.lat & gp_avail;
        end
        gpa_pkg::OFS_DIRECTION: begin
          st_d.rdata = st_q.dir & gp_avail;
        end
        gpa_pkg::OFS_CONV_CFG: begin
          st_d.rdata = {2'b00, st_q.cfg};
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
  end

  // reset leaves every pin floating, all inputs, analog field at zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q.lat <= gpa_pkg::RST_OUT_LATCH;
      st_q.dir <= gpa_pkg::RST_DIRECTION;
      st_q.cfg <= gpa_pkg::RST_CONV_CFG;
      st_q.rdata <= 8'h00;
      st_q.div <= '0;
      st_q.pin_out <= '0;
      st_q.pin_oe_n <= gpa_pkg::RST_PIN_OE_N;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs, all but analog_sel_o from flip-flops; timer tap ignores direction
  assign rdata_o = st_q.rdata;
  assign pin_o = st_q.pin_out;
  assign pin_oe_n_o = st_q.pin_oe_n;
  assign timer_ext_clock_in_o = pin_sync[gpa_pkg::BIT_FOUR];
  assign cycle_clock_out_o = st_q.div[gpa_pkg::DIV_W-1];
  assign analog_sel_o = analog;

endmodule

// [gpa_pkg.sv]
package gpa_pkg;

  // port geometry
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CFG_W = 6;
  localparam int unsigned ANA_CH = 5;

  // register offsets, one byte register per address
  localparam logic [3:0] OFS_PIN_LEVEL = 4'h0;
  localparam logic [3:0] OFS_OUT_LATCH = 4'h1;
  localparam logic [3:0] OFS_DIRECTION = 4'h2;
  localparam logic [3:0] OFS_CONV_CFG = 4'h3;

  // converter_pin_config field positions
  localparam int unsigned PCFG_LSB = 0;
  localparam int unsigned PCFG_W = 4;
  localparam int unsigned REF_LOW_BIT = 4;
  localparam int unsigned REF_HIGH_BIT = 5;

  // reset values
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [5:0] RST_CONV_CFG = 6'h00;
  localparam logic [7:0] RST_PIN_OE_N = 8'hff;

  // special pin positions
  localparam int unsigned BIT_REF_LOW = 2;
  localparam int unsigned BIT_REF_HIGH = 3;
  localparam int unsigned BIT_FOUR = 4;
  localparam int unsigned BIT_SIX = 6;
  localparam int unsigned BIT_SEVEN = 7;
  localparam int unsigned BIT_AN4 = 5;

  // timing: cycle clock is the system clock divided by four
  localparam int unsigned SYS_CLK_NS = 4;
  localparam int unsigned CYC_DIV = 4;
  localparam int unsigned DIV_W = $clog2(CYC_DIV);

  // oscillator configuration seen by the port
  typedef enum logic [2:0] {
    GPA_OSC_XTAL = 3'h0,
    GPA_OSC_EXT_CYCLE_CLOCK_OUT = 3'h1,
    GPA_OSC_EXT_IO = 3'h2,
    GPA_OSC_RC_CYCLE_CLOCK_OUT = 3'h3,
    GPA_OSC_RC_IO = 3'h4,
    GPA_OSC_INT_CYCLE_CLOCK_OUT = 3'h5,
    GPA_OSC_INT_IO = 3'h6
  } gpa_osc_mode_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } gpa_bus_req_t;

  // peripheral claim on pins
  typedef struct packed {
    logic [PORT_W-1:0] own;
    logic [PORT_W-1:0] dat;
    logic [PORT_W-1:0] drv;
  } gpa_periph_t;

endpackage

// [gpa_sync.sv]
`timescale 1ns/10ps
module gpa_sync #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } gpa_sync_st_t;

  gpa_sync_st_t st_q;
  gpa_sync_st_t st_d;

  // a bit changes only once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (st_q.lvl & (st_q.s2 ^ st_q.s3)) | (st_q.s3 & ~(st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;

endmodule

// [gpa_ana_dec.sv]
`timescale 1ns/10ps
module gpa_ana_dec (
  input wire logic [gpa_pkg::CFG_W-1:0] cfg_i,
  output logic [gpa_pkg::PORT_W-1:0] analog_o
);

  logic [gpa_pkg::PCFG_W-1:0] pcfg;
  logic [gpa_pkg::ANA_CH-1:0] ch_ana;

  assign pcfg = cfg_i[gpa_pkg::PCFG_LSB +: gpa_pkg::PCFG_W];

  // lower field values hand more channels to the converter, counting from channel 0
  always_comb begin
    ch_ana = '0;
    for (int k = 0; k < gpa_pkg::ANA_CH; k++) begin
      ch_ana[k] = (32'(pcfg) + 32'(k)) < gpa_pkg::ANA_CH;
    end
  end

  // channels 0..3 sit on pins 0..3, channel 4 on pin 5; reference selects force analog
  always_comb begin
    analog_o = '0;
    analog_o[3:0] = ch_ana[3:0];
    analog_o[gpa_pkg::BIT_AN4] = ch_ana[4];
    if (cfg_i[gpa_pkg::REF_LOW_BIT]) begin
      analog_o[gpa_pkg::BIT_REF_LOW] = 1'b1;
    end
    if (cfg_i[gpa_pkg::REF_HIGH_BIT]) begin
      analog_o[gpa_pkg::BIT_REF_HIGH] = 1'b1;
    end
  end

endmodule

// [gpa_port_asserts.sv]
`timescale 1ns/10ps
module gpa_port_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [7:0] rdata_o,
  input wire gpa_pkg::gpa_osc_mode_t osc_mode_i,
  input wire logic comparator_ref_out_i,
  input wire gpa_pkg::gpa_periph_t periph_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic timer_ext_clock_in_o,
  input wire logic cycle_clock_out_o
);
  logic cycle_clock_out_mode;
  logic ext_osc;
  // modes that claim bit six for the clock or bit seven for the oscillator
  assign cycle_clock_out_mode = osc_mode_i inside {gpa_pkg::GPA_OSC_EXT_CYCLE_CLOCK_OUT, gpa_pkg::GPA_OSC_RC_CYCLE_CLOCK_OUT,
    gpa_pkg::GPA_OSC_INT_CYCLE_CLOCK_OUT};
  assign ext_osc = osc_mode_i < gpa_pkg::GPA_OSC_INT_CYCLE_CLOCK_OUT;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence latch_wr; we_i && addr_i == gpa_pkg::OFS_OUT_LATCH; endsequence
  sequence latch_rd; re_i && addr_i == gpa_pkg::OFS_OUT_LATCH; endsequence
  idle_read_a: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("idle read data");
  latch_back_a: assert property (latch_wr ##1 latch_rd |=>
    rdata_o[5:0] == $past(wdata_i[5:0], 2)) else $error("latch readback");
  unmapped_read_a: assert property (re_i && addr_i > 4'h3 |=> rdata_o == 8'h00)
    else $error("unmapped read");
  clock_shape_a: assert property ($rose(cycle_clock_out_o) |->
    cycle_clock_out_o [*2] ##1 !cycle_clock_out_o [*2] ##1 cycle_clock_out_o)
    else $error("cycle clock shape");
  clock_pin_a: assert property (cycle_clock_out_mode && !periph_i.own[6] |=> !pin_oe_n_o[6])
    else $error("bit six clock");
  // the pin register lags the divider by one edge, so compare with last cycle's tap
  clock_value_a: assert property (cycle_clock_out_mode && !periph_i.own[6] |=>
    pin_o[6] == $past(cycle_clock_out_o)) else $error("bit six clock value");
  osc_bit7_a: assert property (ext_osc && !periph_i.own[7] |=> pin_oe_n_o[7])
    else $error("bit seven driven");
  ref_bit2_a: assert property (comparator_ref_out_i && !periph_i.own[2] |=>
    pin_oe_n_o[2]) else $error("bit two driven");
  open_drain_a: assert property (!periph_i.own[4] ##1 !pin_oe_n_o[4] |-> !pin_o[4])
    else $error("bit four high");
  timer_tap_a: assert property ($stable(pin_i[4]) [*6] |->
    timer_ext_clock_in_o == pin_i[4]) else $error("timer tap");
endmodule

// [gpa_board.sv]
`timescale 1ns/10ps
module gpa_board (
  input wire logic sys_clk_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_level_o
);
  logic flip_q = 1'b0;
  // undriven lines other than bit four wander so a stale level never passes
  always @(posedge sys_clk_i) begin
    flip_q <= ~flip_q;
  end
  // device driver wins; bit four has the pull-up its open drain needs
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (!pin_oe_n_o[k]) begin
        pin_level_o[k] = pin_o[k];
      end else begin
        pin_level_o[k] = ext_en_i[k] ? ext_val_i[k] : (k == 4 || flip_q);
      end
    end
  end
endmodule

// [gpa_port_bench.sv]
`timescale 1ns/10ps
module gpa_port_bench;
  localparam logic [3:0] PIN = gpa_pkg::OFS_PIN_LEVEL;
  localparam logic [3:0] LAT = gpa_pkg::OFS_OUT_LATCH;
  localparam logic [3:0] DIR = gpa_pkg::OFS_DIRECTION;
  localparam logic [3:0] CFG = gpa_pkg::OFS_CONV_CFG;
  localparam logic [6:0] IO6 = 7'h54;
  localparam logic [6:0] IO7 = 7'h60;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic comparator_ref_out_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] ext_val = 8'hff;
  logic [7:0] ext_en = 8'hff;
  logic [7:0] rdata_o, pin_i, pin_o, pin_oe_n_o, analog_sel_o, m;
  logic timer_ext_clock_in_o, cycle_clock_out_o;
  gpa_pkg::gpa_osc_mode_t osc_mode_i = gpa_pkg::GPA_OSC_INT_IO;
  gpa_pkg::gpa_periph_t periph_i = '0;
  int n_errors = 0;
  int n_tests = 0;
  // 250 MHz system clock
  initial forever #2 sys_clk_i = ~sys_clk_i;
  gpa_port i_dut (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .osc_mode_i, .comparator_ref_out_i, .periph_i, .pin_i, .pin_o, .pin_oe_n_o,
    .timer_ext_clock_in_o, .cycle_clock_out_o, .analog_sel_o);
  gpa_board i_board (.sys_clk_i, .pin_o, .pin_oe_n_o, .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_level_o(pin_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // bus tasks start just after an edge and end on one
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    re_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata_o, e);
    @(posedge sys_clk_i);
  endtask
  // driven pins only: floating outputs carry no meaning
  task automatic pins(input logic [7:0] eoe, input logic [7:0] eo);
    @(negedge sys_clk_i);
    chk(pin_oe_n_o, eoe);
    chk(pin_o & ~eoe, eo);
    @(posedge sys_clk_i);
  endtask
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    tick(12);
    rst_n_i <= 1'b1;
    tick(5);
    chk(analog_sel_o, 8'h2f);
    rd(PIN, 8'hd0);
    rd(DIR, 8'hff);
    for (int f = 0; f < 16; f++) begin
      wr(CFG, 8'(f));
      m = 8'h00;
      for (int k = 0; k < 5; k++) begin
        if (f + k < 5) m[k == 4 ? 5 : k] = 1'b1;
      end
      tick(1);
      chk(analog_sel_o, m);
    end
    wr(CFG, 8'hff);
    tick(1);
    chk(analog_sel_o, 8'h0c);
    rd(CFG, 8'h3f);
    wr(CFG, 8'h0f);
    tick(1);
    wr(PIN, 8'hb5);
    rd(LAT, 8'hb5);
    wr(DIR, 8'h00);
    tick(1);
    pins(8'h10, 8'ha5);
    tick(4);
    rd(PIN, 8'hb5);
    wr(LAT, 8'h4e);
    rd(LAT, 8'h4e);
    pins(8'h00, 8'h4e);
    wr(DIR, 8'hff);
    ext_val <= 8'h3c;
    tick(6);
    rd(PIN, 8'h3c);
    rd(LAT, 8'h4e);
    wr(DIR, 8'h00);
    comparator_ref_out_i <= 1'b1;
    periph_i <= '{own: 8'h01, dat: 8'h01, drv: 8'h01};
    tick(1);
    pins(8'h04, 8'h4b);
    tick(4);
    rd(PIN, 8'h4a);
    wr(CFG, 8'h00);
    tick(1);
    pins(8'h04, 8'h4b);
    tick(3);
    rd(PIN, 8'h40);
    comparator_ref_out_i <= 1'b0;
    periph_i <= '0;
    // analog pins are back as inputs, as software must keep them
    wr(DIR, 8'hff);
    ext_val <= 8'h00;
    tick(8);
    @(negedge sys_clk_i);
    chk(8'(timer_ext_clock_in_o), 8'h00);
    @(posedge sys_clk_i);
    ext_en <= 8'hef;
    tick(8);
    @(negedge sys_clk_i);
    chk(8'(timer_ext_clock_in_o), 8'h01);
    @(posedge sys_clk_i);
    wr(LAT, 8'hce);
    tick(1);
    wr(DIR, 8'h00);
    for (int k = 0; k < 7; k++) begin
      osc_mode_i <= gpa_pkg::gpa_osc_mode_t'(k);
      tick(2);
      @(negedge sys_clk_i);
      chk(8'(pin_oe_n_o[7]), 8'(!IO7[k]));
      chk(8'(pin_oe_n_o[6]), 8'(k == 0));
      @(posedge sys_clk_i);
      rd(LAT, {IO7[k], IO6[k], 6'h0e});
    end
    wr(4'h9, 8'hff);
    tick(1);
    rd(4'h9, 8'h00);
    rd(LAT, 8'hce);
    conclude;
  end
endmodule
bind gpa_port gpa_port_asserts i_chk (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i,
  .re_i, .rdata_o, .osc_mode_i, .comparator_ref_out_i, .periph_i, .pin_i, .pin_o,
  .pin_oe_n_o, .timer_ext_clock_in_o, .cycle_clock_out_o);
